// File: verilog/irq_params.svh
// constants for the interrupt request and period generator block
//
// What this block does
// - byte done sets serial flag; call 14H with global and serial enables
// - serving serial call clears serial flag and global enable
// - group flag set when an enabled member flag appears while none was set; call 018H when enabled
// - group call needs global and group enables plus member enable
// - serving group call clears group flag and global; member flags stay
// - conversion end sets conversion flag; call via shared 18H vector
// - each period overflow sets own flag; call needs global, group, own enable
// - period flags conflict resolved: they persist like other member flags
// - control bit 7 turns both period generators on or off
// - bit 6 picks period clock: 0 dedicated source, 1 system clock/4
// - bits 5:4 set period 1 to 4096..32768 clocks
// - bits 2:0 set period 0 to 256 doubled per code, up to 32768
// - bit 3 drives slow crystal low power; all control bits reset 0
// - comparator output change sets comparator flag
// - nonvolatile memory cycle end sets its flag
// - low supply report sets low supply flag
// - no call issued while return stack is full
// - any flag rising wakes core, whatever the enables
// - global enable is bit 0 of first control register
// - flags stay set until served or cleared by software
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

`define ADDR_W           3
`define OFS_CTRL0        3'h0
`define OFS_CTRL1        3'h1
`define OFS_MEMBER0      3'h2
`define OFS_MEMBER1      3'h3
`define OFS_TBC          3'h4

`define CTRL0_GLOBAL_EN  0
`define CTRL1_GROUP_FLAG 6
`define CTRL1_SER_FLAG   5
`define CTRL1_GROUP_EN   2
`define CTRL1_SER_EN     1
`define M0_PERIPH_FLAG   7
`define M0_P1_FLAG       6
`define M0_P0_FLAG       5
`define M0_CONV_FLAG     4
`define M1_LOW_FLAG      6
`define M1_NVM_FLAG      5
`define M1_CMP_FLAG      4
`define MEMBER1_MASK     8'h77

`define TBC_GEN_EN       7
`define TBC_CLK_SEL      6
`define TBC_P1_SEL_MSB   5
`define TBC_P1_SEL_LSB   4
`define TBC_LOW_POWER    3
`define TBC_P0_SEL_MSB   2
`define TBC_P0_SEL_LSB   0

`define REG_RESET        8'h00
`define VEC_SERIAL_ADDR  8'h14
`define VEC_GROUP_ADDR   8'h18
`define SYS_DIV_W        2
`define PERIOD_CNT_W     15
`define P0_BASE_LOG2     8
`define P1_BASE_LOG2     12

`endif

// File: verilog/irq_pkg.sv
// types shared by the interrupt request and period generator block
`include "irq_params.svh"
`default_nettype none
package irq_pkg;

    typedef enum logic [7:0] {
        VEC_SERIAL = `VEC_SERIAL_ADDR,
        VEC_GROUP  = `VEC_GROUP_ADDR
    } vector_e;

    typedef struct packed {
        logic       byte_done;
        logic       conv_done;
        logic       periph_pin_n;
        logic [1:0] cmp_out;
        logic       nvm_done;
        logic       supply_low;
        logic       period_tick;
    } src_events_s;

    typedef struct packed {
        logic    req;
        vector_e vector;
    } call_s;

    typedef struct packed {
        logic [`PERIOD_CNT_W-1:0] cnt;
    } period_state_s;

    typedef struct packed {
        logic                  global_en;
        logic                  serial_en;
        logic                  serial_flag;
        logic                  group_en;
        logic                  group_flag;
        logic [7:0]            member0;
        logic [7:0]            member1;
        logic [7:0]            time_base_control;
        logic [`SYS_DIV_W-1:0] presc;
        logic                  prev_pin_n;
        logic [1:0]            prev_cmp;
        logic                  prev_low;
        logic                  prev_gated;
        logic [7:0]            rdata;
        call_s                 call;
        logic                  wake;
    } ctrl_state_s;

endpackage : irq_pkg
`default_nettype wire

// File: verilog/period_divider.sv
// shared divider chain for both period generators
`include "irq_params.svh"
`default_nettype none
module period_divider
    import irq_pkg::*;
#(
    parameter int CNT_W = `PERIOD_CNT_W
)(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       run,
    input  wire logic       tick,
    input  wire logic [2:0] sel0,
    input  wire logic [1:0] sel1,
    // overflow pulses
    output logic            ovf0,
    output logic            ovf1
);

    period_state_s q;
    period_state_s next_q;

    // true when the low nbits of value are all ones
    function automatic logic low_ones(input logic [CNT_W-1:0] value, input int nbits);
        logic [CNT_W-1:0] mask;
        mask = CNT_W'((32'h1 << nbits) - 32'h1);
        return &(value | ~mask);
    endfunction : low_ones

    always_comb
    begin
        next_q = q;
        if (!run)
            next_q.cnt = '0;
        else if (tick)
            next_q.cnt = q.cnt + 1'b1;
    end

    // period 0 = 2^(8+code), period 1 = 2^(12+code) clocks
    assign ovf0 = run && tick && low_ones(q.cnt, `P0_BASE_LOG2 + int'(sel0));
    assign ovf1 = run && tick && low_ones(q.cnt, `P1_BASE_LOG2 + int'(sel1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= next_q;
    end

endmodule : period_divider
`default_nettype wire

// File: verilog/irq_time_base.sv
// interrupt request flags, enables, vectored calls, wake and period generators
`include "irq_params.svh"
`default_nettype none
module irq_time_base
    import irq_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // register port
    input  wire logic [`ADDR_W-1:0] addr,
    input  wire logic [7:0]         wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output logic [7:0]              rdata,
    // core sequencer
    input  wire logic               stack_full,
    input  wire logic               call_ack,
    output call_s                   call,
    output logic                    wake,
    // peripheral events
    input  wire src_events_s        src,
    // oscillator control
    output logic                    slow_crystal_low_power
);

    ctrl_state_s q;
    ctrl_state_s next_q;
    logic        sys_tick;
    logic        period_tick_sel;
    logic        ovf0;
    logic        ovf1;
    logic        gated;
    logic        cmp_change;
    logic        periph_fall;
    logic        low_rise;

    function automatic logic [7:0] read_word(input ctrl_state_s s,
                                             input logic [`ADDR_W-1:0] a);
        logic [7:0] w;
        w = 8'h00;
        unique case (a)
            `OFS_CTRL0:
                w[`CTRL0_GLOBAL_EN] = s.global_en;
            `OFS_CTRL1:
            begin
                w[`CTRL1_GROUP_FLAG] = s.group_flag;
                w[`CTRL1_SER_FLAG]   = s.serial_flag;
                w[`CTRL1_GROUP_EN]   = s.group_en;
                w[`CTRL1_SER_EN]     = s.serial_en;
            end
            `OFS_MEMBER0:
                w = s.member0;
            `OFS_MEMBER1:
                w = s.member1;
            `OFS_TBC:
                w = s.time_base_control;
            default:
                w = 8'h00;
        endcase
        return w;
    endfunction : read_word

    // all request flags gathered, for wake detection
    function automatic logic [8:0] flags_of(input ctrl_state_s s);
        return {s.serial_flag, s.group_flag, s.member0[7:4], s.member1[6:4]};
    endfunction : flags_of

    // time base clock: dedicated tick or system clock / 4
    assign sys_tick        = &q.presc;
    assign period_tick_sel = q.time_base_control[`TBC_CLK_SEL] ? sys_tick : src.period_tick;

    period_divider u_period_divider (
        .clk   (clk),
        .rst_n (rst_n),
        .run   (q.time_base_control[`TBC_GEN_EN]),
        .tick  (period_tick_sel),
        .sel0  (q.time_base_control[`TBC_P0_SEL_MSB:`TBC_P0_SEL_LSB]),
        .sel1  (q.time_base_control[`TBC_P1_SEL_MSB:`TBC_P1_SEL_LSB]),
        .ovf0  (ovf0),
        .ovf1  (ovf1)
    );

    assign cmp_change  = |(src.cmp_out ^ q.prev_cmp);
    assign periph_fall = q.prev_pin_n && !src.periph_pin_n;
    assign low_rise    = src.supply_low && !q.prev_low;
    // member flags gated by own enables; flag bits line up with enable bits
    assign gated = |(q.member0[7:4] & q.member0[3:0])
                 | |(q.member1[6:4] & q.member1[2:0]);

    always_comb
    begin
        next_q            = q;
        next_q.presc      = q.presc + 1'b1;
        next_q.prev_pin_n = src.periph_pin_n;
        next_q.prev_cmp   = src.cmp_out;
        next_q.prev_low   = src.supply_low;
        next_q.prev_gated = gated;
        next_q.rdata      = rd ? read_word(q, addr) : 8'h00;

        // service: clear global and the served flag only
        if (call_ack)
        begin
            next_q.global_en = 1'b0;
            if (q.call.vector == VEC_SERIAL)
                next_q.serial_flag = 1'b0;
            else
                next_q.group_flag = 1'b0;
        end

        // software writes act directly on flags and enables
        if (wr)
        begin
            unique case (addr)
                `OFS_CTRL0:
                    next_q.global_en = wdata[`CTRL0_GLOBAL_EN];
                `OFS_CTRL1:
                begin
                    next_q.group_flag  = wdata[`CTRL1_GROUP_FLAG];
                    next_q.serial_flag = wdata[`CTRL1_SER_FLAG];
                    next_q.group_en    = wdata[`CTRL1_GROUP_EN];
                    next_q.serial_en   = wdata[`CTRL1_SER_EN];
                end
                `OFS_MEMBER0:
                    next_q.member0 = wdata;
                `OFS_MEMBER1:
                    next_q.member1 = wdata & `MEMBER1_MASK;
                `OFS_TBC:
                    next_q.time_base_control = wdata;
                default:
                    next_q.time_base_control = next_q.time_base_control;
            endcase
        end

        // hardware sets win over any clear in the same cycle
        if (src.byte_done)
            next_q.serial_flag = 1'b1;
        if (periph_fall)
            next_q.member0[`M0_PERIPH_FLAG] = 1'b1;
        if (ovf1)
            next_q.member0[`M0_P1_FLAG] = 1'b1;
        if (ovf0)
            next_q.member0[`M0_P0_FLAG] = 1'b1;
        if (src.conv_done)
            next_q.member0[`M0_CONV_FLAG] = 1'b1;
        if (low_rise)
            next_q.member1[`M1_LOW_FLAG] = 1'b1;
        if (src.nvm_done)
            next_q.member1[`M1_NVM_FLAG] = 1'b1;
        if (cmp_change)
            next_q.member1[`M1_CMP_FLAG] = 1'b1;
        if (gated && !q.prev_gated)
            next_q.group_flag = 1'b1;

        // wake on any flag rising, enables ignored
        next_q.wake = |(~flags_of(q) & flags_of(next_q));

        // call request, serial vector before shared vector
        next_q.call.req = next_q.global_en && !stack_full
            && ((next_q.serial_flag && next_q.serial_en)
             || (next_q.group_flag && next_q.group_en));
        next_q.call.vector = (next_q.serial_flag && next_q.serial_en)
                           ? VEC_SERIAL : VEC_GROUP;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q             <= '0;
            q.time_base_control         <= `REG_RESET;
            q.member0     <= `REG_RESET;
            q.member1     <= `REG_RESET;
            q.prev_pin_n  <= 1'b1;
            q.call.vector <= VEC_SERIAL;
        end
        else
            q <= next_q;
    end

    assign rdata                  = q.rdata;
    assign call                   = q.call;
    assign wake                   = q.wake;
    assign slow_crystal_low_power = q.time_base_control[`TBC_LOW_POWER];

    // checks

    AST_SERIAL_SET: assert property (@(posedge clk) disable iff (!rst_n)
        src.byte_done |=> q.serial_flag)
        else $error("byte done did not set serial flag");

    AST_ACK_CLEARS_GLOBAL: assert property (@(posedge clk) disable iff (!rst_n)
        call_ack && !(wr && addr == `OFS_CTRL0) |=> !q.global_en && !call.req)
        else $error("service did not clear global enable");

    AST_SERIAL_ACK_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        call_ack && call.vector == VEC_SERIAL && !src.byte_done
        && !(wr && addr == `OFS_CTRL1) |=> !q.serial_flag)
        else $error("serial flag survived service");

    AST_GROUP_NEEDS_EN: assert property (@(posedge clk) disable iff (!rst_n)
        call.req && call.vector == VEC_GROUP |-> q.group_en && q.global_en && q.group_flag)
        else $error("shared call without its enables");

    AST_MEMBER_PERSIST: assert property (@(posedge clk) disable iff (!rst_n)
        call_ack && call.vector == VEC_GROUP && q.member0[`M0_CONV_FLAG]
        && !(wr && addr == `OFS_MEMBER0) |=> q.member0[`M0_CONV_FLAG] && !q.group_flag)
        else $error("member flag cleared by service");

    AST_STACK_FULL: assert property (@(posedge clk) disable iff (!rst_n)
        stack_full |=> !call.req)
        else $error("call issued with full stack");

    AST_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(q.member1[`M1_CMP_FLAG]) || $rose(q.serial_flag) |-> wake)
        else $error("flag rise gave no wake");

    AST_CMP_SET: assert property (@(posedge clk) disable iff (!rst_n)
        src.cmp_out != $past(src.cmp_out) |=> q.member1[`M1_CMP_FLAG])
        else $error("comparator change missed");

    AST_GEN_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        !q.time_base_control[`TBC_GEN_EN] |-> !ovf0 && !ovf1)
        else $error("period overflow while generators off");

    AST_GROUP_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
        gated && !q.prev_gated |=> q.group_flag)
        else $error("enabled member rise missed group flag");

    AST_CONV_SET: assert property (@(posedge clk) disable iff (!rst_n)
        src.conv_done |=> q.member0[`M0_CONV_FLAG])
        else $error("conversion end missed its flag");

    AST_NVM_SET: assert property (@(posedge clk) disable iff (!rst_n)
        src.nvm_done |=> q.member1[`M1_NVM_FLAG])
        else $error("memory cycle end missed its flag");

    AST_LOW_SET: assert property (@(posedge clk) disable iff (!rst_n)
        src.supply_low && !q.prev_low |=> q.member1[`M1_LOW_FLAG])
        else $error("low supply missed its flag");

    AST_P0_SET: assert property (@(posedge clk) disable iff (!rst_n)
        ovf0 |=> q.member0[`M0_P0_FLAG])
        else $error("period 0 overflow missed its flag");

    AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        q.serial_flag && !call_ack && !wr |=> q.serial_flag)
        else $error("serial flag dropped without service or write");

endmodule : irq_time_base
`default_nettype wire

// File: testbench/core_model.sv
// core sequencer model that takes vectored calls after a set delay
`default_nettype none
module core_model
    import irq_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // call handshake
    input  wire call_s      call,
    input  wire logic [3:0] delay,
    output logic            call_ack,
    // record of taken calls
    output logic [7:0]      taken_vec,
    output int              taken_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] waited;

    // ack only while the request stands, vector taken in the ack cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            call_ack  <= 1'b0;
            waited    <= 4'h0;
            taken_vec <= 8'h00;
            taken_cnt <= 0;
        end
        else if (call_ack)
        begin
            call_ack  <= 1'b0;
            waited    <= 4'h0;
            taken_vec <= call.vector;
            taken_cnt <= taken_cnt + 1;
        end
        else if (call.req && waited >= delay)
            call_ack <= 1'b1;
        else if (call.req)
            waited <= waited + 4'h1;
        else
            waited <= 4'h0;
    end
endmodule : core_model
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the interrupt request and period generator block
`default_nettype none
module testbench
    import irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        rst_n;
    logic [2:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        stack_full;
    logic        call_ack;
    call_s       call;
    logic        wake;
    src_events_s src;
    logic        slow_crystal_low_power;
    logic [3:0]  delay;
    logic [7:0]  taken_vec;
    int          taken_cnt;
    int          mismatches = 0;
    int          check_count = 0;
    int          wake_cnt = 0;
    int          w0;
    logic [2:0]  gidx [5] = '{3'h2, 3'h3, 3'h3, 3'h3, 3'h2};
    logic [7:0]  gen [5] = '{8'h01, 8'h02, 8'h04, 8'h01, 8'h08};
    logic [7:0]  gflag [5] = '{8'h10, 8'h20, 8'h40, 8'h10, 8'h80};
    logic [7:0]  ptbc [6] = '{8'h80, 8'h81, 8'h82, 8'h87, 8'h97, 8'hC0};
    int          plen [6] = '{256, 512, 1024, 4096, 8192, 1024};
    logic [7:0]  pflag [6] = '{8'h20, 8'h20, 8'h20, 8'h40, 8'h40, 8'h20};

    irq_time_base u_irq_time_base (
        .clk                    (clk),
        .rst_n                  (rst_n),
        .addr                   (addr),
        .wdata                  (wdata),
        .wr                     (wr),
        .rd                     (rd),
        .rdata                  (rdata),
        .stack_full             (stack_full),
        .call_ack               (call_ack),
        .call                   (call),
        .wake                   (wake),
        .src                    (src),
        .slow_crystal_low_power (slow_crystal_low_power)
    );

    core_model u_core_model (
        .clk       (clk),
        .rst_n     (rst_n),
        .call      (call),
        .delay     (delay),
        .call_ack  (call_ack),
        .taken_vec (taken_vec),
        .taken_cnt (taken_cnt)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
        if (wake === 1'b1)
            wake_cnt <= wake_cnt + 1;

    task automatic err(input string msg);
        mismatches++;
        $display("[ERR] %0t %s", $time, msg);
    endtask : err

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
            err($sformatf("byte got %h expected %h", got, exp));
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
            err("bit mismatch");
    endtask : chk_bit

    task automatic close_out;
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : reg_wr

    task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk_byte(rdata, exp);
        @(posedge clk);
    endtask : reg_rd

    // one event of member k, code 5 is a finished serial byte
    task automatic fire(input int k);
        case (k)
            0: src.conv_done <= 1'b1;
            1: src.nvm_done <= 1'b1;
            2: src.supply_low <= 1'b1;
            3: src.cmp_out <= src.cmp_out ^ 2'h1;
            4: src.periph_pin_n <= 1'b0;
            default: src.byte_done <= 1'b1;
        endcase
        @(posedge clk);
        src <= src_events_s'((src & 8'h19) | 8'h20);
        @(posedge clk);
    endtask : fire

    task automatic wait_ack(input logic [7:0] exp);
        int c0;
        int n;
        c0 = taken_cnt;
        n = 0;
        while (taken_cnt == c0 && n < 60)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 60)
        begin
            err("no call taken");
            close_out();
        end
        chk_byte(taken_vec, exp);
    endtask : wait_ack

    task automatic wait_wake(input int exp);
        int c0;
        int n;
        c0 = wake_cnt;
        n = 0;
        while (wake_cnt == c0 && n < exp + 8)
        begin
            @(posedge clk);
            n++;
        end
        if (wake_cnt == c0)
        begin
            err("no wake");
            close_out();
        end
        chk_bit(n >= exp - 8, 1'b1);
    endtask : wait_wake

    initial
    begin
        rst_n = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        stack_full = 1'b0;
        delay = 4'h0;
        src = src_events_s'(8'h21);
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 8; a++)
            reg_rd(3'(a), 8'h00);
        chk_bit(slow_crystal_low_power, 1'b0);
        reg_wr(3'h5, 8'hFF);
        reg_rd(3'h5, 8'h00);
        for (int d = 0; d < 2; d++)
        begin
            delay <= 4'(d * 5);
            reg_wr(3'h1, 8'h02);
            reg_wr(3'h0, 8'h01);
            fire(5);
            wait_ack(8'h14);
            reg_rd(3'h1, 8'h02);
            reg_rd(3'h0, 8'h00);
        end
        stack_full <= 1'b1;
        reg_wr(3'h0, 8'h01);
        fire(5);
        idle(10);
        chk_bit(call.req, 1'b0);
        reg_rd(3'h1, 8'h22);
        stack_full <= 1'b0;
        wait_ack(8'h14);
        for (int k = 0; k < 5; k++)
        begin
            reg_wr(gidx[k], gen[k]);
            reg_wr(3'h1, 8'h04);
            reg_wr(3'h0, 8'h01);
            fire(k);
            wait_ack(8'h18);
            reg_rd(gidx[k], gen[k] | gflag[k]);
            reg_rd(3'h1, 8'h04);
            reg_wr(gidx[k], 8'h00);
        end
        reg_wr(3'h2, 8'h01);
        reg_wr(3'h1, 8'h00);
        reg_wr(3'h0, 8'h01);
        w0 = wake_cnt;
        fire(0);
        idle(10);
        chk_bit(call.req, 1'b0);
        chk_bit(wake_cnt > w0, 1'b1);
        reg_rd(3'h2, 8'h11);
        reg_rd(3'h1, 8'h40);
        reg_wr(3'h1, 8'h00);
        reg_wr(3'h0, 8'h00);
        reg_wr(3'h2, 8'h00);
        w0 = wake_cnt;
        reg_wr(3'h2, 8'h10);
        idle(2);
        chk_bit(wake_cnt == w0 + 1, 1'b1);
        fire(0);
        idle(4);
        chk_bit(wake_cnt == w0 + 1, 1'b1);
        for (int p = 0; p < 6; p++)
        begin
            reg_wr(3'h4, 8'h00);
            reg_wr(3'h2, 8'h00);
            src.period_tick <= ~ptbc[p][6];
            reg_wr(3'h4, ptbc[p]);
            wait_wake(plen[p]);
            reg_rd(3'h2, pflag[p]);
        end
        src.period_tick <= 1'b1;
        reg_wr(3'h4, 8'h01);
        reg_wr(3'h2, 8'h00);
        w0 = wake_cnt;
        idle(600);
        chk_bit(wake_cnt == w0, 1'b1);
        reg_wr(3'h4, 8'h08);
        chk_bit(slow_crystal_low_power, 1'b1);
        reg_rd(3'h4, 8'h08);
        close_out();
    end
endmodule : testbench
`default_nettype wire
